/* design/bank_regs.sv */
// Two banked register sets decoded from six host address bits
//
// Notes on behaviour
// R1: Six address bits, source chosen by port mode
// R2: Offsets 00-1F form lower set, channels 1-8
// R3: Offsets 20-3F duplicate set for channels 9-16
// R4: Four banks per set, one visible
// R5: Lower pointer at 1F, always reachable
// R6: Upper pointer at 3F selects upper banks
// R7: Codes AA secondary, 01 individual, 02 tester
// R8: Pointer 00 is primary, reset value 00
// R9: Each set uses only its own pointer
// R10: Signal-absent irq enable RW at 06/26
// R11: Signal-absent irq status read-only at 08/28
// R12: Driver-fault irq enable RW at 07/27
// R13: Driver-fault irq status read-only at 09/29
// R14: Alarm indication status read-only at 13/33
// R15: Auto all-ones select RW at 0E/2E
// R16: Tester monitor control RW at 0B/2B
// R17: Reserved locations read zero, ignore writes
// R18: Soft reset write restores that set
`timescale 1ns/10ps
`include "bank_regs_map.svh"

module bank_regs (
    // Clock and reset
    input  wire logic                          clock,
    input  wire logic                          reset_n,
    // Host port
    input  wire bank_regs_pkg::port_mode_e     port_mode,
    input  wire logic [5:0]                    addr_direct,
    input  wire logic [5:0]                    addr_shared,
    input  wire logic [6:0]                    addr_serial,
    input  wire logic                          wr_strobe,
    input  wire logic                          rd_strobe,
    input  wire logic [7:0]                    wr_data,
    output logic      [7:0]                    rd_data,
    // Line state per set
    input  wire bank_regs_pkg::set_status_s    line_status [2],
    // Controls and bank choice per set
    output bank_regs_pkg::set_ctrl_s           set_ctrl [2],
    output bank_regs_pkg::bank_e               bank_sel [2]
);

    logic              rst_meta_n;
    logic              rst_n;
    logic [5:0]        addr;
    logic [4:0]        offset;
    logic              set_idx;
    logic [7:0]        regs     [2][32];
    logic [7:0]        sa_irq   [2];
    logic [7:0]        df_irq   [2];
    logic [7:0]        ais_irq  [2];
    logic [7:0]        sa_prev  [2];
    logic [7:0]        df_prev  [2];
    logic [7:0]        ais_prev [2];
    logic [7:0]        next_rd_data;

    // Reset release through two flops
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_n <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_n      <= rst_meta_n;
        end
    end

    // Address source per host port mode
    always_comb begin
        case (port_mode)
            bank_regs_pkg::port_nonmux: addr = addr_direct; // R1
            bank_regs_pkg::port_mux:    addr = addr_shared; // R1
            bank_regs_pkg::port_serial: addr = addr_serial[6:1]; // R1
            default:                    addr = addr_direct;
        endcase
    end

    assign offset  = addr[4:0];
    assign set_idx = addr[`SET_BIT]; // R2 R3

    // Offsets that hold plain read/write storage in the primary bank
    function automatic logic primary_rw(input logic [4:0] off);
        case (off)
            `OFF_ANALOG_LOOPBACK, `OFF_REMOTE_LOOPBACK, `OFF_TX_ALL_ONES_ENABLE,
            `OFF_SIGNAL_ABSENT_IRQ_EN, `OFF_DRIVER_FAULT_IRQ_EN, // R10 R12
            `OFF_TESTER_MONITOR_CTRL, `OFF_DIGITAL_LOOPBACK, // R16
            `OFF_ALARM_CRITERIA_SELECT, `OFF_AUTO_ALL_ONES_SELECT, // R15
            `OFF_GLOBAL_CONFIG, `OFF_TX_TEMPLATE_SELECT, `OFF_LINE_TEMPLATE_SELECT,
            `OFF_OUTPUT_ENABLE_CONFIG, `OFF_ALARM_IND_IRQ_EN: primary_rw = 1'b1;
            default: primary_rw = 1'b0; // R17
        endcase
    endfunction

    function automatic bank_regs_pkg::bank_e decode_bank(input logic [7:0] ptr);
        case (ptr)
            `PTR_PRIMARY:    decode_bank = bank_regs_pkg::bank_primary; // R8
            `PTR_SECONDARY:  decode_bank = bank_regs_pkg::bank_secondary; // R7
            `PTR_INDIVIDUAL: decode_bank = bank_regs_pkg::bank_individual; // R7
            `PTR_TESTER:     decode_bank = bank_regs_pkg::bank_tester; // R7
            default:         decode_bank = bank_regs_pkg::bank_none;
        endcase
    endfunction

    genvar s;
    generate
        for (s = 0; s < 2; s++) begin : g_set
            logic hit;
            logic primary;
            logic wr_hit;
            logic soft_rst;

            assign hit      = (set_idx == 1'(s));
            // Only this set's own pointer picks its bank
            assign bank_sel[s] = decode_bank(regs[s][`OFF_BANK_POINTER]); // R4 R9
            assign primary  = (bank_sel[s] == bank_regs_pkg::bank_primary);
            assign wr_hit   = wr_strobe && hit;
            assign soft_rst = wr_hit && primary && (offset == `OFF_SOFT_RESET); // R18

            // Storage; the pointer is writable in every bank so software can always get back
            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    for (int i = 0; i < 32; i++) begin
                        regs[s][i] <= `REG_RESET; // R8
                    end
                end else if (soft_rst) begin
                    for (int i = 0; i < 32; i++) begin
                        regs[s][i] <= `REG_RESET; // R18
                    end
                end else if (wr_hit && offset == `OFF_BANK_POINTER) begin
                    regs[s][`OFF_BANK_POINTER] <= wr_data; // R5 R6
                end else if (wr_hit && primary && primary_rw(offset)) begin
                    regs[s][offset] <= wr_data; // R10 R12 R15 R16
                end
            end

            // Sticky interrupt status: rising line state sets, a read clears, set wins
            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    sa_prev[s]  <= `REG_RESET;
                    df_prev[s]  <= `REG_RESET;
                    ais_prev[s] <= `REG_RESET;
                    sa_irq[s]   <= `REG_RESET;
                    df_irq[s]   <= `REG_RESET;
                    ais_irq[s]  <= `REG_RESET;
                end else begin
                    sa_prev[s]  <= line_status[s].signal_absent;
                    df_prev[s]  <= line_status[s].driver_fault;
                    ais_prev[s] <= line_status[s].alarm_indication;
                    if (soft_rst) begin
                        sa_irq[s]  <= `REG_RESET;
                        df_irq[s]  <= `REG_RESET;
                        ais_irq[s] <= `REG_RESET;
                    end else begin
                        sa_irq[s]  <= ((rd_strobe && hit && primary && offset == `OFF_SIGNAL_ABSENT_IRQ_STAT)
                                       ? 8'h00 : sa_irq[s])
                                      | (line_status[s].signal_absent & ~sa_prev[s]); // R11
                        df_irq[s]  <= ((rd_strobe && hit && primary && offset == `OFF_DRIVER_FAULT_IRQ_STAT)
                                       ? 8'h00 : df_irq[s])
                                      | (line_status[s].driver_fault & ~df_prev[s]); // R13
                        ais_irq[s] <= ((rd_strobe && hit && primary && offset == `OFF_ALARM_IND_IRQ_STAT)
                                       ? 8'h00 : ais_irq[s])
                                      | (line_status[s].alarm_indication & ~ais_prev[s]);
                    end
                end
            end

            assign set_ctrl[s].analog_loopback        = regs[s][`OFF_ANALOG_LOOPBACK];
            assign set_ctrl[s].remote_loopback        = regs[s][`OFF_REMOTE_LOOPBACK];
            assign set_ctrl[s].tx_all_ones_enable     = regs[s][`OFF_TX_ALL_ONES_ENABLE];
            assign set_ctrl[s].tester_monitor_control = regs[s][`OFF_TESTER_MONITOR_CTRL];
            assign set_ctrl[s].digital_loopback       = regs[s][`OFF_DIGITAL_LOOPBACK];
            assign set_ctrl[s].alarm_criteria_select  = regs[s][`OFF_ALARM_CRITERIA_SELECT];
            assign set_ctrl[s].auto_all_ones_select   = regs[s][`OFF_AUTO_ALL_ONES_SELECT];
            assign set_ctrl[s].global_config          = regs[s][`OFF_GLOBAL_CONFIG];
            assign set_ctrl[s].tx_template_select     = regs[s][`OFF_TX_TEMPLATE_SELECT];
            assign set_ctrl[s].line_template_select   = regs[s][`OFF_LINE_TEMPLATE_SELECT];
            assign set_ctrl[s].output_enable_config   = regs[s][`OFF_OUTPUT_ENABLE_CONFIG];
        end
    endgenerate

    // Read mux; non-primary bank contents live outside this block and read as zero here
    always_comb begin
        next_rd_data = 8'h00;
        if (offset == `OFF_BANK_POINTER) begin
            next_rd_data = regs[set_idx][`OFF_BANK_POINTER]; // R5 R6
        end else if (bank_sel[set_idx] == bank_regs_pkg::bank_primary) begin
            case (offset)
                `OFF_CHIP_VERSION_CODE:      next_rd_data = set_idx ? 8'h00 : `CHIP_VERSION_DEFAULT; // R17
                `OFF_SIGNAL_ABSENT_STATUS:   next_rd_data = line_status[set_idx].signal_absent;
                `OFF_DRIVER_FAULT_STATUS:    next_rd_data = line_status[set_idx].driver_fault;
                `OFF_SIGNAL_ABSENT_IRQ_STAT: next_rd_data = sa_irq[set_idx]; // R11
                `OFF_DRIVER_FAULT_IRQ_STAT:  next_rd_data = df_irq[set_idx]; // R13
                `OFF_ALARM_IND_STATUS:       next_rd_data = line_status[set_idx].alarm_indication; // R14
                `OFF_ALARM_IND_IRQ_STAT:     next_rd_data = ais_irq[set_idx];
                default:                     next_rd_data = primary_rw(offset) ? regs[set_idx][offset] : 8'h00; // R17
            endcase
        end
    end

    // Read data held until the next read
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= 8'h00;
        end else if (rd_strobe) begin
            rd_data <= next_rd_data;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    a_ptr_write_lower: assert property (wr_strobe && addr == 6'h1F |=> regs[0][31] == $past(wr_data)) // R5
        else $error("Lower pointer did not take write");
    a_ptr_write_upper: assert property (wr_strobe && addr == 6'h3F |=> regs[1][31] == $past(wr_data)) // R6
        else $error("Upper pointer did not take write");
    a_set_isolation: assert property (wr_strobe && addr == 6'h3F |=> $stable(regs[0][31])) // R9
        else $error("Upper pointer write moved lower pointer");
    a_bank_decode: assert property (regs[0][31] == 8'hAA |-> bank_sel[0] == bank_regs_pkg::bank_secondary) // R7
        else $error("Secondary code not decoded");
    a_soft_reset_ptr: assert property (wr_strobe && addr == 6'h0A && bank_sel[0] == bank_regs_pkg::bank_primary
                                       |=> regs[0][31] == 8'h00 && bank_sel[0] == bank_regs_pkg::bank_primary) // R18
        else $error("Soft reset left pointer set");
    a_reserved_zero: assert property (rd_strobe && addr[4:0] >= 5'h16 && addr[4:0] <= 5'h1E |=> rd_data == 8'h00) // R17
        else $error("Reserved location read nonzero");
    a_upper_id_zero: assert property (rd_strobe && addr == 6'h20 |=> rd_data == 8'h00) // R17
        else $error("Unused upper id slot read nonzero");
    // A write must not touch the sticky status; a line event in the same cycle would, so it is excluded
    a_status_ro: assert property (wr_strobe && !rd_strobe && addr == 6'h08
                                  && (line_status[0].signal_absent & ~sa_prev[0]) == 8'h00
                                  |=> sa_irq[0] == $past(sa_irq[0])) // R11
        else $error("Status location took a write");
    a_enable_rw: assert property (wr_strobe && addr == 6'h26 && bank_sel[1] == bank_regs_pkg::bank_primary
                                  ##1 rd_strobe && addr == 6'h26 && !wr_strobe |=> rd_data == $past(wr_data, 2)) // R10
        else $error("Irq enable did not read back");
    a_irq_sticky: assert property ($rose(line_status[0].driver_fault[0]) && !(wr_strobe && addr == 6'h0A)
                                   |=> df_irq[0][0]) // R13
        else $error("Driver fault event lost");
    a_ais_read: assert property (rd_strobe && addr == 6'h33 && bank_sel[1] == bank_regs_pkg::bank_primary
                                 |=> rd_data == $past(line_status[1].alarm_indication)) // R14
        else $error("Alarm status read wrong");
    a_tester_write: assert property (wr_strobe && addr == 6'h0B && bank_sel[0] == bank_regs_pkg::bank_primary
                                     |=> set_ctrl[0].tester_monitor_control == $past(wr_data)) // R16
        else $error("Tester control not written");
    a_auto_ones: assert property (wr_strobe && addr == 6'h2E && bank_sel[1] == bank_regs_pkg::bank_primary
                                  |=> set_ctrl[1].auto_all_ones_select == $past(wr_data)) // R15
        else $error("Auto all-ones select not written");

    c_select_tester: cover property (wr_strobe && addr == 6'h1F && wr_data == 8'h02);
    c_upper_soft_reset: cover property (wr_strobe && addr == 6'h2A);
    c_irq_read_clear: cover property (df_irq[0] != 8'h00 ##1 rd_strobe && addr == 6'h09);
    c_serial_access: cover property (port_mode == bank_regs_pkg::port_serial && rd_strobe);
    c_write_then_read: cover property (wr_strobe && addr == 6'h26 ##1 rd_strobe && addr == 6'h26);

endmodule

/* design/bank_regs_map.svh */
// Register offsets, codes and reset values of the banked register space
`ifndef BANK_REGS_MAP_SVH
`define BANK_REGS_MAP_SVH

`define OFF_CHIP_VERSION_CODE      5'h00
`define OFF_ANALOG_LOOPBACK        5'h01
`define OFF_REMOTE_LOOPBACK        5'h02
`define OFF_TX_ALL_ONES_ENABLE     5'h03
`define OFF_SIGNAL_ABSENT_STATUS   5'h04
`define OFF_DRIVER_FAULT_STATUS    5'h05
`define OFF_SIGNAL_ABSENT_IRQ_EN   5'h06
`define OFF_DRIVER_FAULT_IRQ_EN    5'h07
`define OFF_SIGNAL_ABSENT_IRQ_STAT 5'h08
`define OFF_DRIVER_FAULT_IRQ_STAT  5'h09
`define OFF_SOFT_RESET             5'h0A
`define OFF_TESTER_MONITOR_CTRL    5'h0B
`define OFF_DIGITAL_LOOPBACK       5'h0C
`define OFF_ALARM_CRITERIA_SELECT  5'h0D
`define OFF_AUTO_ALL_ONES_SELECT   5'h0E
`define OFF_GLOBAL_CONFIG          5'h0F
`define OFF_TX_TEMPLATE_SELECT     5'h10
`define OFF_LINE_TEMPLATE_SELECT   5'h11
`define OFF_OUTPUT_ENABLE_CONFIG   5'h12
`define OFF_ALARM_IND_STATUS       5'h13
`define OFF_ALARM_IND_IRQ_EN       5'h14
`define OFF_ALARM_IND_IRQ_STAT     5'h15
`define OFF_BANK_POINTER           5'h1F

`define SET_BIT                    5

`define PTR_PRIMARY                8'h00
`define PTR_SECONDARY              8'hAA
`define PTR_INDIVIDUAL             8'h01
`define PTR_TESTER                 8'h02

`define REG_RESET                  8'h00
// Arbitrary value
`define CHIP_VERSION_DEFAULT       8'h5A

`endif

/* design/bank_regs_pkg.sv */
// Types shared by the banked register space
package bank_regs_pkg;

    typedef enum logic [1:0] {
        port_nonmux = 2'b00,
        port_mux    = 2'b01,
        port_serial = 2'b10
    } port_mode_e;

    typedef enum logic [2:0] {
        bank_primary    = 3'b000,
        bank_secondary  = 3'b001,
        bank_individual = 3'b010,
        bank_tester     = 3'b011,
        bank_none       = 3'b100
    } bank_e;

    typedef struct packed {
        logic [7:0] analog_loopback;
        logic [7:0] remote_loopback;
        logic [7:0] tx_all_ones_enable;
        logic [7:0] tester_monitor_control;
        logic [7:0] digital_loopback;
        logic [7:0] alarm_criteria_select;
        logic [7:0] auto_all_ones_select;
        logic [7:0] global_config;
        logic [7:0] tx_template_select;
        logic [7:0] line_template_select;
        logic [7:0] output_enable_config;
    } set_ctrl_s;

    typedef struct packed {
        logic [7:0] signal_absent;
        logic [7:0] driver_fault;
        logic [7:0] alarm_indication;
    } set_status_s;

endpackage

/* verification/host_model.sv */
// Host processor model that drives the register port
`timescale 1ns/10ps
module host_model (
    // Clock
    input  wire logic                     clock,
    // Register port
    output bank_regs_pkg::port_mode_e     port_mode,
    output logic [5:0]                    addr_direct,
    output logic [5:0]                    addr_shared,
    output logic [6:0]                    addr_serial,
    output logic                          wr_strobe,
    output logic                          rd_strobe,
    output logic [7:0]                    wr_data,
    // Read return
    input  wire logic [7:0]               rd_data
);
    initial begin
        port_mode = bank_regs_pkg::port_nonmux;
        addr_direct = 6'h3F;
        addr_shared = 6'h3F;
        addr_serial = 7'h7F;
        wr_strobe = 1'b0;
        rd_strobe = 1'b0;
        wr_data = 8'hFF;
    end

    // Unused sources carry the inverse, so a wrong source choice shows
    task automatic access(input bank_regs_pkg::port_mode_e mode, input logic [5:0] a, input logic we,
                          input logic [7:0] d, output logic [7:0] rdata);
        @(posedge clock);
        #1;
        port_mode = mode;
        addr_direct = (mode == bank_regs_pkg::port_nonmux) ? a : ~a;
        addr_shared = (mode == bank_regs_pkg::port_mux) ? a : ~a;
        addr_serial = (mode == bank_regs_pkg::port_serial) ? {a, ~a[0]} : {~a, a[0]};
        wr_strobe = we;
        rd_strobe = !we;
        wr_data = we ? d : ~d;
        @(posedge clock);
        #1;
        rdata = rd_data;
        wr_strobe = 1'b0;
        rd_strobe = 1'b0;
        wr_data = ~wr_data;
    endtask

    // Write then read of one location in consecutive cycles, as the port allows back to back
    task automatic write_read(input bank_regs_pkg::port_mode_e mode, input logic [5:0] a,
                              input logic [7:0] d, output logic [7:0] rdata);
        @(posedge clock);
        #1;
        port_mode = mode;
        addr_direct = (mode == bank_regs_pkg::port_nonmux) ? a : ~a;
        addr_shared = (mode == bank_regs_pkg::port_mux) ? a : ~a;
        addr_serial = (mode == bank_regs_pkg::port_serial) ? {a, ~a[0]} : {~a, a[0]};
        wr_strobe = 1'b1;
        wr_data = d;
        @(posedge clock);
        #1;
        wr_strobe = 1'b0;
        rd_strobe = 1'b1;
        wr_data = ~d;
        @(posedge clock);
        #1;
        rdata = rd_data;
        rd_strobe = 1'b0;
    endtask
endmodule

/* verification/testbench.sv */
// Self-checking bench for the banked register space
`timescale 1ns/10ps
`include "bank_regs_map.svh"
module testbench;
    logic                         clock = 1'b0;
    logic                         reset_n = 1'b0;
    bank_regs_pkg::port_mode_e    port_mode;
    logic [5:0]                   addr_direct;
    logic [5:0]                   addr_shared;
    logic [6:0]                   addr_serial;
    logic                         wr_strobe;
    logic                         rd_strobe;
    logic [7:0]                   wr_data;
    logic [7:0]                   rd_data;
    bank_regs_pkg::set_status_s   line_status [2];
    bank_regs_pkg::set_ctrl_s     set_ctrl [2];
    bank_regs_pkg::bank_e         bank_sel [2];
    int                           err_count = 0;
    int                           compares = 0;
    logic [7:0]                   shadow [64];
    logic [7:0]                   ptr [2];
    logic [7:0]                   got;
    logic [7:0]                   d8;
    logic [7:0]                   codes [5] = '{8'hAA, 8'h01, 8'h02, 8'h55, 8'h00};
    logic [4:0]                   ro_offs [8] = '{5'h04, 5'h05, 5'h08, 5'h09, 5'h13, 5'h16, 5'h1E, 5'h0A};
    logic [4:0]                   rw_offs [13] = '{5'h01, 5'h02, 5'h03, 5'h06, 5'h07, 5'h0B, 5'h0C,
                                                   5'h0D, 5'h0E, 5'h0F, 5'h10, 5'h11, 5'h12};
    bank_regs_pkg::set_status_s   x;

    always #25 clock = ~clock;

    bank_regs u_bank_regs (.clock(clock), .reset_n(reset_n), .port_mode(port_mode), .addr_direct(addr_direct),
        .addr_shared(addr_shared), .addr_serial(addr_serial), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe),
        .wr_data(wr_data), .rd_data(rd_data), .line_status(line_status), .set_ctrl(set_ctrl), .bank_sel(bank_sel));
    host_model u_host_model (.clock(clock), .port_mode(port_mode), .addr_direct(addr_direct),
        .addr_shared(addr_shared), .addr_serial(addr_serial), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe),
        .wr_data(wr_data), .rd_data(rd_data));

    task automatic stop_test();
        $display("mismatches %0d of %0d comparisons", err_count, compares);
        if (err_count == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic bank_regs_pkg::port_mode_e rnd_mode();
        return bank_regs_pkg::port_mode_e'($urandom_range(2));
    endfunction

    function automatic logic [2:0] exp_bank(input logic [7:0] c);
        case (c)
            8'h00: return 3'b000;
            8'hAA: return 3'b001;
            8'h01: return 3'b010;
            8'h02: return 3'b011;
            default: return 3'b100;
        endcase
    endfunction

    function automatic logic [7:0] exp_val(input logic [5:0] a);
        if (a[4:0] == 5'h1F) return ptr[a[5]];
        if (ptr[a[5]] != 8'h00) return 8'h00;
        if (a == 6'h00) return `CHIP_VERSION_DEFAULT;
        if (a[4:0] == 5'h04) return line_status[a[5]].signal_absent;
        if (a[4:0] == 5'h05) return line_status[a[5]].driver_fault;
        if (a[4:0] == 5'h13) return line_status[a[5]].alarm_indication;
        return shadow[a];
    endfunction

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        logic [7:0] unused;
        u_host_model.access(rnd_mode(), a, 1'b1, d, unused);
        if (ptr[a[5]] == 8'h00 && a[4:0] inside {rw_offs, 5'h14}) shadow[a] = d;
        if (ptr[a[5]] == 8'h00 && a[4:0] == 5'h0A)
            for (int i = 0; i < 32; i++) shadow[{a[5], i[4:0]}] = 8'h00;
        if (a[4:0] == 5'h1F) ptr[a[5]] = d;
    endtask

    task automatic rd(input logic [5:0] a);
        u_host_model.access(rnd_mode(), a, 1'b0, 8'h00, got);
    endtask

    task automatic rd_chk(input logic [5:0] a);
        rd(a);
        check(got, exp_val(a));
    endtask

    initial begin
        repeat (20000) @(posedge clock);
        err_count++;
        stop_test();
    end

    initial begin
        void'($urandom(7557));
        line_status = '{default: '0};
        foreach (shadow[i]) shadow[i] = 8'h00;
        ptr = '{8'h00, 8'h00};
        repeat (20) @(posedge clock);
        #1;
        reset_n = 1'b1;
        repeat (4) @(posedge clock);
        check({5'b0, bank_sel[0]}, 8'h00);
        check({5'b0, bank_sel[1]}, 8'h00);
        rd_chk(6'h1F);
        rd_chk(6'h3F);
        rd_chk(6'h00);
        rd_chk(6'h20);
        // Random traffic over the primary-bank RW locations of both sets except 14/34, every port mode
        repeat (60) begin
            logic [5:0] a;
            a = {1'($urandom_range(1)), rw_offs[$urandom_range(12)]};
            wr(a, 8'($urandom));
            rd_chk(a);
            check(set_ctrl[a[5]].tester_monitor_control, shadow[{a[5], 5'h0B}]);
            check(set_ctrl[a[5]].auto_all_ones_select, shadow[{a[5], 5'h0E}]);
        end
        // Write and read back to back on the upper signal-absent enable
        d8 = 8'($urandom);
        u_host_model.write_read(rnd_mode(), 6'h26, d8, got);
        shadow[6'h26] = d8;
        check(got, d8);
        // Writes to read-only, reserved and write-only places leave nothing behind
        for (int s = 0; s < 2; s++) foreach (ro_offs[i]) begin
            wr({s[0], ro_offs[i]}, 8'($urandom) | 8'h01);
            rd_chk({s[0], ro_offs[i]});
        end
        // Every pointer code in each set, the other set must not follow
        for (int s = 0; s < 2; s++) foreach (codes[i]) begin
            wr({s[0], 5'h1F}, codes[i]);
            check({5'b0, bank_sel[s]}, {5'b0, exp_bank(codes[i])});
            check({5'b0, bank_sel[1-s]}, 8'h00);
            wr({s[0], 5'h0E}, 8'($urandom));
            rd_chk({s[0], 5'h0E});
            rd_chk({s[0], 5'h1F});
        end
        // Line events raise the upper irq status only, a read clears it
        x = bank_regs_pkg::set_status_s'(24'($urandom) | 24'h01_0101);
        @(posedge clock);
        #1;
        line_status[1] = x;
        repeat (2) @(posedge clock);
        rd_chk(6'h33);
        rd(6'h28);
        check(got, x.signal_absent);
        rd(6'h28);
        check(got, 8'h00);
        rd(6'h29);
        check(got, x.driver_fault);
        rd(6'h35);
        check(got, x.alarm_indication);
        rd(6'h08);
        check(got, 8'h00);
        // The same events on the lower line raise the lower driver-fault status
        @(posedge clock);
        #1;
        line_status[0] = x;
        repeat (2) @(posedge clock);
        rd(6'h09);
        check(got, x.driver_fault);
        // Soft reset of the lower set leaves the upper set intact
        wr(6'h0A, 8'($urandom));
        check({7'b0, |set_ctrl[0]}, 8'h00);
        foreach (rw_offs[i]) begin
            rd_chk({1'b0, rw_offs[i]});
            rd_chk({1'b1, rw_offs[i]});
        end
        stop_test();
    end
endmodule
